//--- rtl/serial_master_port_timing.sv
`timescale 1ns/1ps
`include "serial_port_timing_defs.svh"

// How it works
// - One or two stop bits per character
// - Hold response by configured milliseconds
// - Delay first byte after raising RTS
// - Keep RTS high after last byte
// - Optionally transmit only while CTS high
// - Wait before poll request after ACK
// - Walk only configured number of commands
// - Space first issue of successive commands
// - Retries go out without command spacing
// - Log command errors unless pointer disabled
// - Reply timeout counts in milliseconds
// - Retransmit when no reply before timeout
// - Retry failing command at most limit
// - Skip failed slave for configured polls
// - Write per-slave status unless pointer disabled
// - Port role: master or slave
// - Link: full or half duplex
module serial_master_port_timing #(
  parameter int TICK_CYCLES = int'(`CLK_HZ / `MS_PER_S * `TICK_MS),
  parameter int SLAVES = 256
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic resp_req,
  input wire logic [7:0] cmd_slave,
  input wire logic reply_rx,
  input wire logic ack_rx,
  input wire logic tx_last,
  input wire logic cts_in,
  output logic rts,
  output logic tx_allow,
  output logic frame_go,
  output serial_port_timing_pkg::frame_kind_t frame_kind,
  output logic [6:0] cmd_index,
  output logic two_stop_bits,
  output serial_port_timing_pkg::db_wr_t err_wr,
  output serial_port_timing_pkg::db_wr_t stat_wr,
  output logic irq
);

  function automatic logic [15:0] word_index(input logic [15:0] a);
    return {2'h0, a[15:2]};
  endfunction

  logic [15:0] cfg [`CFG_WORDS];
  logic [1:0] port_mode;
  logic [`IRQ_W-1:0] irq_status;
  logic [`IRQ_W-1:0] irq_enable;
  serial_port_timing_pkg::state_t state;
  serial_port_timing_pkg::state_t next_state;
  logic [15:0] prescale;
  logic [15:0] ms_count;
  logic [3:0] retries;
  logic [7:0] cur_slave;
  logic [SLAVES-1:0] skip_live;
  logic [15:0] skip_left [SLAVES];

  // Bus decode
  wire [15:0] idx = word_index(paddr);
  wire [15:0] cfg_off = idx - `IDX_STOP_BITS;
  wire [3:0] cfg_sel = cfg_off[3:0];
  wire hit_cfg = (idx >= `IDX_STOP_BITS) && (idx <= `IDX_STATUS_RATE);
  wire hit_mode = idx == `IDX_PORT_MODE;
  wire hit_status = idx == `IDX_IRQ_STATUS;
  wire hit_clear = idx == `IDX_IRQ_CLEAR;
  wire hit_enable = idx == `IDX_IRQ_ENABLE;
  wire mapped = (paddr[1:0] == 2'h0) && (hit_cfg || hit_mode || hit_status || hit_clear || hit_enable);
  wire setup = psel && !penable;
  wire wr_take = psel && penable && pwrite && mapped;
  wire [31:0] read_word = hit_cfg ? {16'h0000, cfg[cfg_sel]} :
                          hit_mode ? {30'h0, port_mode} :
                          hit_status ? {28'h0, irq_status} :
                          hit_enable ? {28'h0, irq_enable} : 32'h0;
  wire [`IRQ_W-1:0] clear_mask = (wr_take && hit_clear) ? pwdata[`IRQ_W-1:0] : 4'h0;

  // Named configuration words
  wire [15:0] stop_bit_count = cfg[`SLOT_STOP];
  wire [15:0] response_hold_ms = cfg[`SLOT_RESP_HOLD];
  wire [15:0] rts_assert_lead_ms = cfg[`SLOT_RTS_LEAD];
  wire [15:0] rts_release_lag_ms = cfg[`SLOT_RTS_LAG];
  wire [15:0] cts_gating_select = cfg[`SLOT_CTS_SEL];
  wire [15:0] poll_request_wait_ms = cfg[`SLOT_ENQ_WAIT];
  wire [15:0] command_list_length = cfg[`SLOT_CMD_COUNT];
  wire [15:0] command_spacing_ms = cfg[`SLOT_CMD_SPACING];
  wire [15:0] error_log_base = cfg[`SLOT_ERR_BASE];
  wire [15:0] reply_timeout_ms = cfg[`SLOT_REPLY_TIMEOUT];
  wire [15:0] retry_limit = cfg[`SLOT_RETRY_LIMIT];
  wire [15:0] failed_slave_skip_polls = cfg[`SLOT_SKIP_POLLS];
  wire [15:0] slave_status_base = cfg[`SLOT_STATUS_BASE];

  wire is_master = !port_mode[`MODE_ROLE];
  wire half_duplex = port_mode[`MODE_HALF];
  wire [6:0] eff_count = (command_list_length > `CMD_COUNT_MAX) ? 7'h64 : command_list_length[6:0];
  wire [3:0] retry_lim = (retry_limit > `RETRY_MAX) ? 4'ha : retry_limit[3:0];
  wire stop_bad = (stop_bit_count != `STOP_ONE) && (stop_bit_count != `STOP_TWO);
  wire cfg_bad = stop_bad || (command_list_length > `CMD_COUNT_MAX) || (retry_limit > `RETRY_MAX);

  // Delay selection per state
  wire [15:0] delay_target = (state == serial_port_timing_pkg::st_spacing) ? command_spacing_ms :
                             (state == serial_port_timing_pkg::st_resp_hold) ? response_hold_ms :
                             (state == serial_port_timing_pkg::st_rts_lead) ? rts_assert_lead_ms :
                             (state == serial_port_timing_pkg::st_rts_lag) ? rts_release_lag_ms :
                             (state == serial_port_timing_pkg::st_enq_wait) ? poll_request_wait_ms :
                             (state == serial_port_timing_pkg::st_await_reply) ? reply_timeout_ms : 16'h0000;
  wire delay_done = ms_count >= delay_target;
  wire restart = state != next_state;
  wire tick_end = prescale == 16'(TICK_CYCLES - 1);
  wire ms_tick = tick_end && !restart;

  // Command sequencing
  wire in_idle = state == serial_port_timing_pkg::st_idle;
  wire awaiting = state == serial_port_timing_pkg::st_await_reply;
  wire master_go = in_idle && is_master && (eff_count != 7'h00);
  wire skip_now = master_go && skip_live[cmd_slave] && (skip_left[cmd_slave] != 16'h0000);
  wire enq_req = awaiting && !reply_rx && half_duplex && ack_rx;
  wire ev_done = awaiting && reply_rx;
  wire ev_timeout = awaiting && !reply_rx && !enq_req && delay_done;
  wire do_retry = ev_timeout && (retries < retry_lim);
  wire ev_fail = ev_timeout && !do_retry;
  wire advance = skip_now || ev_done || ev_fail;
  wire [7:0] idx_inc = {1'b0, cmd_index} + 8'h01;
  wire [6:0] next_index = (idx_inc >= {1'b0, eff_count}) ? 7'h00 : idx_inc[6:0];
  wire err_ok = error_log_base <= `ERR_PTR_MAX;
  wire stat_ok = slave_status_base <= `STATUS_PTR_MAX;
  wire cts_ok = !cts_gating_select[0] || cts_in;
  wire next_rts = (next_state == serial_port_timing_pkg::st_rts_lead) ||
                  (next_state == serial_port_timing_pkg::st_send) ||
                  (next_state == serial_port_timing_pkg::st_rts_lag);
  wire [`IRQ_W-1:0] irq_events = {cfg_bad, ev_timeout, ev_fail, ev_done};

  assign pready = 1'b1;
  assign tx_allow = (state == serial_port_timing_pkg::st_send) && cts_ok;
  assign irq = |(irq_status & irq_enable);

  always_comb
  begin
    next_state = state;
    unique case (state)
      serial_port_timing_pkg::st_idle:
        if (master_go && !skip_now)
          next_state = serial_port_timing_pkg::st_spacing;
        else if (!is_master && resp_req)
          next_state = serial_port_timing_pkg::st_resp_hold;
      serial_port_timing_pkg::st_spacing:
        if (delay_done)
          next_state = serial_port_timing_pkg::st_rts_lead;
      serial_port_timing_pkg::st_resp_hold:
        if (delay_done)
          next_state = serial_port_timing_pkg::st_rts_lead;
      serial_port_timing_pkg::st_rts_lead:
        if (delay_done)
          next_state = serial_port_timing_pkg::st_send;
      serial_port_timing_pkg::st_send:
        if (tx_last)
          next_state = serial_port_timing_pkg::st_rts_lag;
      serial_port_timing_pkg::st_rts_lag:
        if (delay_done)
          next_state = (frame_kind == serial_port_timing_pkg::kind_response) ?
                       serial_port_timing_pkg::st_idle : serial_port_timing_pkg::st_await_reply;
      serial_port_timing_pkg::st_await_reply:
        if (ev_done || ev_fail)
          next_state = serial_port_timing_pkg::st_idle;
        else if (enq_req)
          next_state = serial_port_timing_pkg::st_enq_wait;
        else if (do_retry)
          next_state = serial_port_timing_pkg::st_rts_lead;
      serial_port_timing_pkg::st_enq_wait:
        if (delay_done)
          next_state = serial_port_timing_pkg::st_rts_lead;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? 32'h0 : read_word;
      pslverr <= !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < `CFG_WORDS; i++)
        cfg[i] <= 16'h0000;
      cfg[`SLOT_STOP] <= `STOP_BITS_RST;
      port_mode <= 2'h0;
      irq_enable <= 4'h0;
    end
    else if (wr_take)
    begin
      if (hit_cfg && (cfg_sel < `CFG_WRITABLE))
        cfg[cfg_sel] <= pwdata[15:0];
      if (hit_mode)
        port_mode <= pwdata[1:0];
      if (hit_enable)
        irq_enable <= pwdata[`IRQ_W-1:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= 4'h0;
    else
      irq_status <= (irq_status & ~clear_mask) | irq_events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prescale <= 16'h0000;
      ms_count <= 16'h0000;
    end
    else
    begin
      prescale <= (restart || tick_end) ? 16'h0000 : prescale + 16'h0001;
      if (restart)
        ms_count <= 16'h0000;
      else if (ms_tick && (ms_count != 16'hffff))
        ms_count <= ms_count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= serial_port_timing_pkg::st_idle;
      rts <= 1'b0;
      frame_go <= 1'b0;
      two_stop_bits <= 1'b0;
    end
    else
    begin
      state <= next_state;
      rts <= next_rts;
      frame_go <= (state == serial_port_timing_pkg::st_rts_lead) && (next_state == serial_port_timing_pkg::st_send);
      two_stop_bits <= stop_bit_count == `STOP_TWO;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_kind <= serial_port_timing_pkg::kind_cmd;
      cmd_index <= 7'h00;
      retries <= 4'h0;
      cur_slave <= 8'h00;
    end
    else
    begin
      if (in_idle && next_state == serial_port_timing_pkg::st_spacing)
      begin
        frame_kind <= serial_port_timing_pkg::kind_cmd;
        retries <= 4'h0;
        cur_slave <= cmd_slave;
      end
      else if (in_idle && next_state == serial_port_timing_pkg::st_resp_hold)
        frame_kind <= serial_port_timing_pkg::kind_response;
      else if (do_retry)
      begin
        frame_kind <= serial_port_timing_pkg::kind_retry;
        retries <= retries + 4'h1;
      end
      else if (state == serial_port_timing_pkg::st_enq_wait && delay_done)
        frame_kind <= serial_port_timing_pkg::kind_enq;
      if (advance)
        cmd_index <= next_index;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_wr <= '0;
      stat_wr <= '0;
      skip_live <= '0;
    end
    else
    begin
      err_wr.valid <= ev_fail && err_ok;
      err_wr.addr <= error_log_base + {9'h000, cmd_index};
      err_wr.data <= {4'h0, retries, cur_slave};
      stat_wr.valid <= (ev_done || ev_fail) && stat_ok;
      stat_wr.addr <= slave_status_base + {8'h00, cur_slave};
      stat_wr.data <= ev_done ? `SLAVE_OK : `SLAVE_FAILED;
      if (ev_fail)
        skip_live[cur_slave] <= 1'b1;
      else if (ev_done)
        skip_live[cur_slave] <= 1'b0;
    end
  end

  // Skip counters hold data only; skip_live qualifies them after reset
  always_ff @(posedge pclk)
  begin
    if (ev_fail)
      skip_left[cur_slave] <= failed_slave_skip_polls;
    else if (skip_now)
      skip_left[cmd_slave] <= skip_left[cmd_slave] - 16'h0001;
  end

  // Sequencing and timing checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_stop_bits: assert property ($stable(stop_bit_count) |-> two_stop_bits == (stop_bit_count == `STOP_TWO))
    else $error("stop bit select wrong");
  a_resp_hold: assert property ((state == serial_port_timing_pkg::st_resp_hold) && restart |->
    ms_count >= response_hold_ms) else $error("response sent early");
  a_rts_lead: assert property ($rose(frame_go) |-> rts && $past(rts) &&
    $past(ms_count) >= $past(rts_assert_lead_ms)) else $error("byte before rts lead");
  a_rts_lag: assert property ($fell(rts) |-> $past(state) == serial_port_timing_pkg::st_rts_lag &&
    $past(ms_count) >= $past(rts_release_lag_ms)) else $error("rts dropped early");
  a_cts_gate: assert property (tx_allow && cts_gating_select[0] |-> cts_in)
    else $error("sent without cts");
  a_enq_wait: assert property ((state == serial_port_timing_pkg::st_enq_wait) && restart |->
    half_duplex && ms_count >= poll_request_wait_ms) else $error("enq too soon");
  // An empty list parks the index at zero
  a_cmd_count: assert property (advance |=> ($past(eff_count) == 7'h00) ? (cmd_index == 7'h00) :
    (cmd_index < $past(eff_count))) else $error("index past count");
  a_cmd_spacing: assert property ((state == serial_port_timing_pkg::st_spacing) && restart |->
    ms_count >= command_spacing_ms) else $error("spacing short");
  a_retry_direct: assert property (do_retry |=> state == serial_port_timing_pkg::st_rts_lead)
    else $error("retry delayed");
  a_err_ptr: assert property (err_wr.valid |-> $past(ev_fail) && $past(error_log_base) <= `ERR_PTR_MAX)
    else $error("error write not allowed");
  a_timeout: assert property (awaiting && restart && !reply_rx && !ack_rx |->
    ms_count >= reply_timeout_ms) else $error("timeout early");
  a_retry_limit: assert property (retries <= `RETRY_MAX)
    else $error("retries exceed limit");
  a_skip_slave: assert property (skip_now |=> state == serial_port_timing_pkg::st_idle)
    else $error("skipped slave polled");
  a_status_ptr: assert property (stat_wr.valid |-> $past(slave_status_base) <= `STATUS_PTR_MAX)
    else $error("status write not allowed");
  a_ms_restart: assert property (restart |=> ms_count == 16'h0000 ##1 ms_count <= 16'h0001)
    else $error("counter not restarted");

  // Main scenarios
  c_cmd_done: cover property (ev_done);
  c_retry: cover property (do_retry ##[1:1000] frame_go);
  c_enq: cover property (enq_req);
  c_response: cover property (frame_go && frame_kind == serial_port_timing_pkg::kind_response);
  c_skip: cover property (skip_now);

endmodule

//--- rtl/serial_port_timing_defs.svh
`ifndef SERIAL_PORT_TIMING_DEFS_SVH
`define SERIAL_PORT_TIMING_DEFS_SVH

// Register word indices; the byte address is four times the index
`define IDX_STOP_BITS 16'h139a
`define IDX_RESP_HOLD 16'h139b
`define IDX_RTS_LEAD 16'h139c
`define IDX_RTS_LAG 16'h139d
`define IDX_CTS_SEL 16'h139e
`define IDX_ENQ_WAIT 16'h139f
`define IDX_CMD_COUNT 16'h13a0
`define IDX_CMD_SPACING 16'h13a1
`define IDX_ERR_BASE 16'h13a2
`define IDX_REPLY_TIMEOUT 16'h13a3
`define IDX_RETRY_LIMIT 16'h13a4
`define IDX_SKIP_POLLS 16'h13a5
`define IDX_STATUS_BASE 16'h13a6
`define IDX_STATUS_RATE 16'h13a7
`define IDX_PORT_MODE 16'h13b0
`define IDX_IRQ_STATUS 16'h13b1
`define IDX_IRQ_CLEAR 16'h13b2
`define IDX_IRQ_ENABLE 16'h13b3

// Config array slots
`define CFG_WORDS 14
`define CFG_WRITABLE 4'hd
`define SLOT_STOP 4'h0
`define SLOT_RESP_HOLD 4'h1
`define SLOT_RTS_LEAD 4'h2
`define SLOT_RTS_LAG 4'h3
`define SLOT_CTS_SEL 4'h4
`define SLOT_ENQ_WAIT 4'h5
`define SLOT_CMD_COUNT 4'h6
`define SLOT_CMD_SPACING 4'h7
`define SLOT_ERR_BASE 4'h8
`define SLOT_REPLY_TIMEOUT 4'h9
`define SLOT_RETRY_LIMIT 4'ha
`define SLOT_SKIP_POLLS 4'hb
`define SLOT_STATUS_BASE 4'hc

// Reset values and limits
`define STOP_BITS_RST 16'h0001
`define STOP_ONE 16'h0001
`define STOP_TWO 16'h0002
`define CMD_COUNT_MAX 16'h0064
`define RETRY_MAX 16'h000a
`define ERR_PTR_MAX 16'h1387
`define STATUS_PTR_MAX 16'h1287
`define SLAVE_OK 16'h0001
`define SLAVE_FAILED 16'h0002

// Port mode bits
`define MODE_ROLE 0
`define MODE_HALF 1

// Interrupt bits
`define IRQ_W 4
`define IRQ_DONE 0
`define IRQ_FAIL 1
`define IRQ_TIMEOUT 2
`define IRQ_CFG 3

// Timing: 50 MHz clock, 1 ms tick
`define CLK_HZ 32'h02faf080
`define MS_PER_S 32'h000003e8
`define TICK_MS 32'h00000001

`endif

//--- rtl/serial_port_timing_pkg.sv
package serial_port_timing_pkg;

  typedef enum logic [2:0] {
    st_idle, st_spacing, st_resp_hold, st_rts_lead, st_send, st_rts_lag, st_await_reply, st_enq_wait
  } state_t;

  typedef enum logic [1:0] {
    kind_cmd, kind_retry, kind_enq, kind_response
  } frame_kind_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] data;
  } db_wr_t;

endpackage

//--- verif/remote_station.sv
`timescale 1ns/1ps
// Far-side station: clocks bytes out while allowed, answers after RTS drops
module remote_station (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rts,
  input wire logic tx_allow,
  input wire logic answer,
  input wire logic ack_first,
  input wire logic cts_level,
  output logic tx_last,
  output logic reply_rx,
  output logic ack_rx,
  output logic cts_in
);
  logic [3:0] byte_cnt;
  logic [3:0] wait_cnt;
  logic pending;
  logic acked;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byte_cnt <= 4'h0;
      wait_cnt <= 4'h0;
      pending <= 1'b0;
      acked <= 1'b0;
      tx_last <= 1'b0;
      reply_rx <= 1'b0;
      ack_rx <= 1'b0;
      cts_in <= 1'b0;
    end
    else
    begin
      cts_in <= cts_level;
      tx_last <= tx_allow && byte_cnt == 4'h2;
      byte_cnt <= tx_allow ? byte_cnt + 4'h1 : 4'h0;
      if (tx_last)
        pending <= 1'b1;
      reply_rx <= 1'b0;
      ack_rx <= 1'b0;
      if (pending && !rts)
      begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == 4'h2)
        begin
          if (ack_first && !acked)
            ack_rx <= 1'b1;
          else
            reply_rx <= answer;
          acked <= ack_first && !acked;
          pending <= 1'b0;
          wait_cnt <= 4'h0;
        end
      end
    end
  end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
`include "serial_port_timing_defs.svh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, resp_req = 1'b0, answer = 1'b1, cts_level = 1'b1, ack_first = 1'b0, rts_q = 1'b0;
  logic reply_rx, ack_rx, tx_last, cts_in, rts, tx_allow, frame_go, two_stop_bits, irq;
  logic [7:0] cmd_slave;
  logic [6:0] cmd_index;
  serial_port_timing_pkg::frame_kind_t frame_kind;
  serial_port_timing_pkg::db_wr_t err_wr, stat_wr, last_err, last_stat;
  int failures = 0, samples_checked = 0, cyc = 0, rts_at = 0, go_at = 0, n, stat_cnt = 0;
  always #10 pclk = ~pclk;
  assign cmd_slave = 8'h10 + {1'b0, cmd_index};
  serial_master_port_timing #(.TICK_CYCLES(4), .SLAVES(256)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .resp_req(resp_req), .cmd_slave(cmd_slave), .reply_rx(reply_rx), .ack_rx(ack_rx),
    .tx_last(tx_last), .cts_in(cts_in), .rts(rts), .tx_allow(tx_allow), .frame_go(frame_go),
    .frame_kind(frame_kind), .cmd_index(cmd_index), .two_stop_bits(two_stop_bits), .err_wr(err_wr),
    .stat_wr(stat_wr), .irq(irq));
  remote_station far (.pclk(pclk), .presetn(presetn), .rts(rts), .tx_allow(tx_allow), .answer(answer),
    .ack_first(ack_first), .cts_level(cts_level), .tx_last(tx_last), .reply_rx(reply_rx), .ack_rx(ack_rx),
    .cts_in(cts_in));
  // Record database writes and RTS/frame timing
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    rts_q <= rts;
    if (rts === 1'b1 && rts_q === 1'b0)
      rts_at <= cyc;
    if (frame_go === 1'b1)
      go_at <= cyc;
    if (err_wr.valid === 1'b1)
      last_err <= err_wr;
    if (stat_wr.valid === 1'b1)
    begin
      last_stat <= stat_wr;
      stat_cnt <= stat_cnt + 1;
    end
    if (cyc == 40000)
    begin
      chk("cycle_limit", 32'h0, 32'h1);
      summarize();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [15:0] ba(input logic [15:0] idx);
    ba = {idx[13:0], 2'b00};
  endfunction
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 50);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb(1'b1, ba(idx), d);
  endtask
  task automatic rdchk(input string name, input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, ba(idx), 32'h0);
    chk(name, exp, rd);
  endtask
  task automatic wait_go();
    n = 0;
    do
      @(posedge pclk);
    while (frame_go !== 1'b1 && ++n < 3000);
    chk("frame_go", 32'h1, {31'h0, frame_go});
    #1;
  endtask
  task automatic wait_stat();
    int start;
    start = stat_cnt;
    n = 0;
    while (stat_cnt == start && n < 5000)
    begin
      @(posedge pclk);
      n = n + 1;
    end
    #1;
    chk("stat_wr", 32'h1, {31'h0, stat_cnt != start});
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Register defaults, reserved word and an unmapped address
    rdchk("stop_bit_count", `IDX_STOP_BITS, 32'h0000_0001);
    for (logic [15:0] i = `IDX_RESP_HOLD; i <= `IDX_STATUS_BASE; i++)
      rdchk("config_default", i, 32'h0);
    wr(`IDX_STATUS_RATE, 32'h0000_ffff);
    rdchk("unused_status_rate", `IDX_STATUS_RATE, 32'h0);
    apb(1'b0, 16'h0010, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    $display("test registers done");
    wr(`IDX_STOP_BITS, 32'h0000_0002);
    @(posedge pclk);
    #1;
    chk("two_stop", 32'h1, {31'h0, two_stop_bits});
    wr(`IDX_STOP_BITS, 32'h0000_0001);
    @(posedge pclk);
    #1;
    chk("one_stop", 32'h0, {31'h0, two_stop_bits});
    $display("test stop bits done");
    // Master poll with a replying slave
    wr(`IDX_RTS_LEAD, 32'h0000_0002);
    wr(`IDX_STATUS_BASE, 32'h0000_0100);
    wr(`IDX_ERR_BASE, 32'h0000_0200);
    wr(`IDX_REPLY_TIMEOUT, 32'h0000_0005);
    wr(`IDX_RETRY_LIMIT, 32'h0000_0001);
    wr(`IDX_CMD_SPACING, 32'h0000_0001);
    wr(`IDX_IRQ_ENABLE, 32'h0000_0001);
    wr(`IDX_CMD_COUNT, 32'h0000_0002);
    wait_go();
    chk("kind_cmd", 32'h0, {30'h0, frame_kind});
    chk("lead_min", 32'h1, {31'h0, go_at - rts_at >= 8});
    chk("lead_max", 32'h1, {31'h0, go_at - rts_at <= 11});
    wait_stat();
    chk("stat_ok", {16'h0110, 16'h0001}, {last_stat.addr, last_stat.data});
    wait_stat();
    chk("stat_second", {16'h0111, 16'h0001}, {last_stat.addr, last_stat.data});
    wr(`IDX_CMD_COUNT, 32'h0);
    repeat (120) @(posedge pclk);
    chk("index_wrap", 32'h0, {25'h0, cmd_index});
    rdchk("irq_status", `IDX_IRQ_STATUS, 32'h1);
    chk("irq_up", 32'h1, {31'h0, irq});
    wr(`IDX_IRQ_ENABLE, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`IDX_IRQ_CLEAR, 32'h1);
    rdchk("irq_cleared", `IDX_IRQ_STATUS, 32'h0);
    $display("test master poll done");
    // Silent slave: one retry, then error log and failed status
    answer <= 1'b0;
    wr(`IDX_SKIP_POLLS, 32'h0000_0002);
    wr(`IDX_CMD_COUNT, 32'h0000_0001);
    wait_go();
    wait_go();
    chk("kind_retry", 32'h1, {30'h0, frame_kind});
    wait_stat();
    chk("stat_fail", {16'h0110, 16'h0002}, {last_stat.addr, last_stat.data});
    chk("err_log", {16'h0200, 16'h0110}, {last_err.addr, last_err.data});
    wr(`IDX_CMD_COUNT, 32'h0);
    repeat (200) @(posedge pclk);
    $display("test timeout done");
    // Clear-to-send gating holds the transmitter
    answer <= 1'b1;
    cts_level <= 1'b0;
    wr(`IDX_CTS_SEL, 32'h1);
    wr(`IDX_CMD_COUNT, 32'h0000_0001);
    wait_go();
    repeat (10) @(posedge pclk);
    chk("cts_block", 32'h0, {31'h0, tx_allow});
    cts_level <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("cts_open", 32'h1, {31'h0, tx_allow});
    wr(`IDX_CMD_COUNT, 32'h0);
    repeat (200) @(posedge pclk);
    $display("test cts done");
    // Half duplex: the slave acknowledges, then the master polls for the data
    wr(`IDX_PORT_MODE, 32'h2);
    wr(`IDX_ENQ_WAIT, 32'h1);
    ack_first <= 1'b1;
    wr(`IDX_CMD_COUNT, 32'h0000_0001);
    wait_go();
    wait_go();
    chk("kind_enq", 32'h2, {30'h0, frame_kind});
    wait_stat();
    chk("stat_half", {16'h0110, 16'h0001}, {last_stat.addr, last_stat.data});
    wr(`IDX_CMD_COUNT, 32'h0);
    ack_first <= 1'b0;
    repeat (200) @(posedge pclk);
    $display("test half duplex done");
    // Slave role answers a ready response
    wr(`IDX_PORT_MODE, 32'h1);
    wr(`IDX_RESP_HOLD, 32'h1);
    @(posedge pclk);
    resp_req <= 1'b1;
    @(posedge pclk);
    resp_req <= 1'b0;
    wait_go();
    chk("kind_resp", 32'h3, {30'h0, frame_kind});
    $display("test slave done");
    summarize();
  end
endmodule
